// file: remote_cal_ctrl.sv
// Remote calibration, valve, range and serial control top
//
// The APB register port and the placing of the registers were chosen for this implementation.
`default_nettype none
module remote_cal_ctrl
  import remote_cal_pkg::*;
#(
  parameter int unsigned BAUD_DIV   = BAUD_CYCLES,
  parameter int unsigned REPORT_CYC = REPORT_CYCLES,
  parameter int unsigned CAL_CYC    = CAL_CYCLES
) (
  input  wire logic        pclk,          // System clock
  input  wire logic        presetn,       // Async reset, active low
  input  wire logic        psel,          // APB select
  input  wire logic        penable,       // APB access phase
  input  wire logic        pwrite,        // APB write
  input  wire logic [7:0]  paddr,         // APB byte address
  input  wire logic [31:0] pwdata,        // APB write data
  output logic      [31:0] prdata,        // APB read data
  output logic             pready,        // APB ready
  output logic             pslverr,       // APB error
  input  wire logic        zero_req,      // Remote zero input pin
  input  wire logic        span_req,      // Remote span input pin
  input  wire logic        rxd,           // Serial input pin
  output logic             txd,           // Serial output pin
  output logic             cal_contact,   // Closed while calibrating
  output logic             low_range_contact,     // Low_range_contact
  output logic             medium_range_contact,  // Medium_range_contact
  output logic             high_range_contact,    // High_range_contact
  output logic             air_cal_range_contact, // Air_cal_range_contact
  output logic             sample_valve,  // Sample gas valve
  output logic             zero_valve,    // Zero gas valve
  output logic             span_valve,    // Span gas valve
  output logic             exhaust_valve  // Exhaust valve
);
  // ****************************************************
  // Helper functions
  // ****************************************************
  function automatic logic [7:0] hex_char(input logic [3:0] v);
    hex_char = (v < 4'hA) ? {4'h3, v} : (8'h37 + {4'h0, v});
  endfunction

  function automatic logic [7:0] range_char(input logic [1:0] r);
    unique case (r)
      2'h0: range_char = 8'h4C;  // L
      2'h1: range_char = 8'h4D;  // M
      2'h2: range_char = 8'h48;  // H
      2'h3: range_char = 8'h41;  // A
    endcase
  endfunction

  // ****************************************************
  // Pin synchronisers (three stages, 2nd and 3rd agree)
  // ****************************************************
  logic [2:0] s1_r;
  logic [2:0] s2_r;
  logic [2:0] s3_r;
  logic [2:0] pin_r;
  logic       zero_in;
  logic       span_in;
  logic       rx_in;

  // Shift pins through three stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 3'h4;
      s2_r <= 3'h4;
      s3_r <= 3'h4;
    end else begin
      s1_r <= {rxd, span_req, zero_req};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Accept a change once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_r <= 3'h4;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (s2_r[i] == s3_r[i]) pin_r[i] <= s3_r[i];
      end
    end
  end

  assign zero_in = pin_r[0];
  assign span_in = pin_r[1];
  assign rx_in   = pin_r[2];

  // ****************************************************
  // Serial command parser
  // ****************************************************
  logic       rx_valid;
  logic [7:0] rx_data;
  logic [23:0] line_r;
  logic [2:0]  len_r;
  logic        cmd_span_r;
  logic        cmd_zero_r;
  logic        cmd_stat_r;
  logic        cmd_rng_r;
  logic [1:0]  cmd_rng_val_r;

  uart_rx #(.DIV(BAUD_DIV)) u_rx (
    .pclk    (pclk),
    .presetn (presetn),
    .rxd     (rx_in),
    .valid_r (rx_valid),
    .data_r  (rx_data)
  );

  // Collect a line, decode on enter, drop anything else
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_r        <= 24'h000000;
      len_r         <= 3'h0;
      cmd_span_r    <= 1'b0;
      cmd_zero_r    <= 1'b0;
      cmd_stat_r    <= 1'b0;
      cmd_rng_r     <= 1'b0;
      cmd_rng_val_r <= 2'h0;
    end else begin
      cmd_span_r <= 1'b0;
      cmd_zero_r <= 1'b0;
      cmd_stat_r <= 1'b0;
      cmd_rng_r  <= 1'b0;
      if (rx_valid && rx_data == CH_CR) begin
        len_r <= 3'h0;
        if (len_r == 3'h2) begin
          cmd_span_r <= line_r[15:0] == {CH_A, CH_S};
          cmd_zero_r <= line_r[15:0] == {CH_A, CH_Z};
          cmd_stat_r <= line_r[15:0] == {CH_S, CH_T};
        end
        if (len_r == 3'h3 && line_r[23:8] == {CH_R, CH_M} &&
            line_r[7:0] >= CH_1 && line_r[7:0] <= CH_3) begin
          cmd_rng_r     <= 1'b1;
          cmd_rng_val_r <= 2'(line_r[7:0] - CH_1);
        end
      end else if (rx_valid && rx_data != CH_LF) begin
        line_r <= {line_r[15:0], rx_data};
        if (len_r != 3'h4) len_r <= len_r + 3'h1;  // Overlong line
      end
    end
  end

  // ****************************************************
  // Calibration mode machine
  // ****************************************************
  mode_t       mode_r;
  logic [31:0] cal_cnt_r;
  logic        start_zero;
  logic        start_span;

  // Requests only count in analysis, so none can be queued
  assign start_zero = zero_in || cmd_zero_r;
  assign start_span = span_in || cmd_span_r;

  // Analysis polls inputs; calibration ignores them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r    <= ANALYZE;
      cal_cnt_r <= 32'h00000000;
    end else begin
      unique case (mode_r)
        ANALYZE: begin
          cal_cnt_r <= 32'(CAL_CYC - 1);
          if (start_zero) begin
            mode_r <= ZERO_CAL;
          end else if (start_span) begin
            mode_r <= SPAN_CAL;
          end
        end
        ZERO_CAL, SPAN_CAL: begin
          // Back to analysis; a held input re-enters
          if (cal_cnt_r == 32'h00000000) begin
            mode_r <= ANALYZE;
          end else begin
            cal_cnt_r <= cal_cnt_r - 32'h00000001;
          end
        end
        default: mode_r <= ANALYZE;
      endcase
    end
  end

  // ****************************************************
  // Contacts and valves
  // ****************************************************
  logic [1:0] range_r;

  // Activity contact and valve lines follow the mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_contact   <= 1'b0;
      sample_valve  <= 1'b0;
      zero_valve    <= 1'b0;
      span_valve    <= 1'b0;
      exhaust_valve <= 1'b0;
    end else begin
      cal_contact   <= mode_r != ANALYZE;
      sample_valve  <= mode_r == ANALYZE;
      zero_valve    <= mode_r == ZERO_CAL;
      span_valve    <= mode_r == SPAN_CAL;
      exhaust_valve <= mode_r != ANALYZE;
    end
  end

  // One-hot range identification contacts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_range_contact     <= 1'b0;
      medium_range_contact  <= 1'b0;
      high_range_contact    <= 1'b0;
      air_cal_range_contact <= 1'b0;
    end else begin
      low_range_contact     <= range_r == 2'h0;
      medium_range_contact  <= range_r == 2'h1;
      high_range_contact    <= range_r == 2'h2;
      air_cal_range_contact <= range_r == 2'h3;
    end
  end

  // ****************************************************
  // APB register file
  // ****************************************************
  logic        stat_en_r;
  logic [15:0] conc_r;
  logic [15:0] span_r;
  logic [7:0]  alarm_r;
  logic        acc;
  logic        wr;
  logic        hit;

  assign acc = psel && penable && !pready;
  assign wr  = acc && pwrite;
  assign hit = paddr == CTRL_OFS || paddr == STATUS_OFS ||
               paddr == CONC_OFS || paddr == SPAN_OFS ||
               paddr == ALARM_OFS;

  // Range from software or serial command; serial wins a tie
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      range_r <= RANGE_RST;
    end else if (cmd_rng_r) begin
      range_r <= cmd_rng_val_r;
    end else if (wr && paddr == CTRL_OFS) begin
      range_r <= pwdata[CTRL_RANGE_LSB +: 2];
    end
  end

  // Status output enable, toggled by command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_en_r <= STAT_EN_RST;
    end else if (cmd_stat_r) begin
      stat_en_r <= !stat_en_r;
    end else if (wr && paddr == CTRL_OFS) begin
      stat_en_r <= pwdata[CTRL_STAT_BIT];
    end
  end

  // Report data written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conc_r  <= CONC_RST;
      span_r  <= SPAN_RST;
      alarm_r <= ALARM_RST;
    end else if (wr) begin
      if (paddr == CONC_OFS)  conc_r  <= pwdata[15:0];
      if (paddr == SPAN_OFS)  span_r  <= pwdata[15:0];
      if (paddr == ALARM_OFS) alarm_r <= pwdata[7:0];
    end
  end

  // One wait state, registered answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= acc;
      pslverr <= acc && !hit;
      prdata  <= 32'h00000000;
      if (acc && !pwrite) begin
        unique case (paddr)
          CTRL_OFS:   prdata <= {29'h0, stat_en_r, range_r};
          STATUS_OFS: prdata <= {26'h0, pin_r[1:0], cal_contact,
                                 (mode_r == SPAN_CAL),
                                 (mode_r == ZERO_CAL), 1'b0};
          CONC_OFS:   prdata <= {16'h0, conc_r};
          SPAN_OFS:   prdata <= {16'h0, span_r};
          ALARM_OFS:  prdata <= {24'h0, alarm_r};
          default:    prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ****************************************************
  // Periodic status report
  // ****************************************************
  logic [31:0] tick_r;
  logic [4:0]  idx_r;
  logic        rep_r;
  logic        tx_busy;
  logic        tx_go;
  logic [7:0]  tx_byte;
  logic [3:0]  dis_nib;
  logic [3:0]  trip_nib;

  assign dis_nib  = alarm_r[3:0];
  assign trip_nib = alarm_r[ALARM_TRIP_LSB +: 4];
  assign tx_go    = rep_r && !tx_busy;

  // Report bytes: conc, range, span, disabled, tripped
  always_comb begin
    unique case (idx_r)
      5'h00:   tx_byte = hex_char(conc_r[15:12]);
      5'h01:   tx_byte = hex_char(conc_r[11:8]);
      5'h02:   tx_byte = hex_char(conc_r[7:4]);
      5'h03:   tx_byte = hex_char(conc_r[3:0]);
      5'h06:   tx_byte = range_char(range_r);
      5'h09:   tx_byte = hex_char(span_r[15:12]);
      5'h0A:   tx_byte = hex_char(span_r[11:8]);
      5'h0B:   tx_byte = hex_char(span_r[7:4]);
      5'h0C:   tx_byte = hex_char(span_r[3:0]);
      5'h0F:   tx_byte = hex_char(dis_nib);
      5'h12:   tx_byte = hex_char(trip_nib);
      5'h04, 5'h07, 5'h0D, 5'h10, 5'h13: tx_byte = CH_CR;
      default: tx_byte = CH_LF;
    endcase
  end

  // Interval timer and byte sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_r <= 32'h00000000;
      idx_r  <= 5'h00;
      rep_r  <= 1'b0;
    end else begin
      if (tick_r == 32'(REPORT_CYC - 1)) begin
        tick_r <= 32'h00000000;
        if (stat_en_r && !rep_r) begin
          rep_r <= 1'b1;
          idx_r <= 5'h00;
        end
      end else begin
        tick_r <= tick_r + 32'h00000001;
      end
      if (tx_go) begin
        if (idx_r == REPORT_LEN - 5'h01) rep_r <= 1'b0;
        idx_r <= idx_r + 5'h01;
      end
    end
  end

  uart_tx #(.DIV(BAUD_DIV)) u_tx (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (tx_go),
    .data    (tx_byte),
    .busy_r  (tx_busy),
    .txd_r   (txd)
  );
endmodule
`default_nettype wire

// file: remote_cal_pkg.sv
// Constants and types shared by the remote calibration controller
`default_nettype none
package remote_cal_pkg;
  // ****************************************************
  // Clock and timing
  // ****************************************************
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned BAUD_RATE     = 9600;
  localparam int unsigned BAUD_CYCLES   = CLK_HZ / BAUD_RATE;
  localparam int unsigned REPORT_SEC    = 2;
  localparam int unsigned REPORT_CYCLES = REPORT_SEC * CLK_HZ;
  localparam int unsigned CAL_MS        = 1000;
  localparam int unsigned CAL_CYCLES    = CAL_MS * (CLK_HZ / 1000);
  localparam int unsigned DATA_BITS     = 8;

  // ****************************************************
  // Register map
  // ****************************************************
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] CONC_OFS   = 8'h08;
  localparam logic [7:0] SPAN_OFS   = 8'h0C;
  localparam logic [7:0] ALARM_OFS  = 8'h10;
  localparam int unsigned CTRL_RANGE_LSB = 0;
  localparam int unsigned CTRL_STAT_BIT  = 2;
  localparam int unsigned ALARM_TRIP_LSB = 4;
  localparam logic [1:0]  RANGE_RST      = 2'h0;
  localparam logic        STAT_EN_RST    = 1'b1;
  localparam logic [15:0] CONC_RST       = 16'h0000;
  localparam logic [15:0] SPAN_RST       = 16'h0000;
  localparam logic [7:0]  ALARM_RST      = 8'h00;

  // ****************************************************
  // Characters
  // ****************************************************
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_A  = 8'h61;
  localparam logic [7:0] CH_S  = 8'h73;
  localparam logic [7:0] CH_Z  = 8'h7A;
  localparam logic [7:0] CH_T  = 8'h74;
  localparam logic [7:0] CH_R  = 8'h72;
  localparam logic [7:0] CH_M  = 8'h6D;
  localparam logic [7:0] CH_1  = 8'h31;
  localparam logic [7:0] CH_3  = 8'h33;
  localparam logic [4:0] REPORT_LEN = 5'h15;

  typedef enum logic [1:0] {ANALYZE, ZERO_CAL, SPAN_CAL} mode_t;
endpackage
`default_nettype wire

// file: uart_rx.sv
// Serial receiver, 8 data bits, no parity, one stop bit
`default_nettype none
module uart_rx
  import remote_cal_pkg::*;
#(
  parameter int unsigned DIV = BAUD_CYCLES
) (
  input  wire logic       pclk,     // System clock
  input  wire logic       presetn,  // Async reset, active low
  input  wire logic       rxd,      // Filtered serial input
  output logic            valid_r,  // One-cycle byte strobe
  output logic [7:0]      data_r    // Received byte
);
  logic [15:0] cnt_r;
  logic [3:0]  bit_r;
  logic        busy_r;
  logic [7:0]  sh_r;

  // Start edge, mid-bit sampling, stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r   <= 16'h0000;
      bit_r   <= 4'h0;
      busy_r  <= 1'b0;
      sh_r    <= 8'h00;
      valid_r <= 1'b0;
      data_r  <= 8'h00;
    end else begin
      valid_r <= 1'b0;
      if (!busy_r) begin
        if (!rxd) begin
          busy_r <= 1'b1;
          bit_r  <= 4'h0;
          cnt_r  <= 16'(DIV / 2);
        end
      end else if (cnt_r != 16'h0000) begin
        cnt_r <= cnt_r - 16'h0001;
      end else begin
        cnt_r <= 16'(DIV - 1);
        bit_r <= bit_r + 4'h1;
        if (bit_r == 4'h0) begin
          if (rxd) busy_r <= 1'b0;  // Glitch, not a start bit
        end else if (bit_r <= 4'(DATA_BITS)) begin
          sh_r <= {rxd, sh_r[7:1]};
        end else begin
          busy_r  <= 1'b0;
          valid_r <= rxd;           // Framing error drops byte
          data_r  <= sh_r;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: uart_tx.sv
// Serial transmitter, 8 data bits, no parity, one stop bit
`default_nettype none
module uart_tx
  import remote_cal_pkg::*;
#(
  parameter int unsigned DIV = BAUD_CYCLES
) (
  input  wire logic       pclk,     // System clock
  input  wire logic       presetn,  // Async reset, active low
  input  wire logic       start,    // Send byte, taken when idle
  input  wire logic [7:0] data,     // Byte to send
  output logic            busy_r,   // Transmitter occupied
  output logic            txd_r     // Serial output, idle high
);
  logic [15:0] cnt_r;
  logic [3:0]  bit_r;
  logic [9:0]  sh_r;

  // Frame shifter: start, 8 data LSB first, stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r  <= 16'h0000;
      bit_r  <= 4'h0;
      sh_r   <= 10'h3FF;
      busy_r <= 1'b0;
      txd_r  <= 1'b1;
    end else if (!busy_r) begin
      if (start) begin
        busy_r <= 1'b1;
        sh_r   <= {1'b1, data, 1'b0};
        bit_r  <= 4'h0;
        cnt_r  <= 16'h0000;
      end
    end else if (cnt_r != 16'h0000) begin
      cnt_r <= cnt_r - 16'h0001;
    end else if (bit_r == 4'hA) begin
      busy_r <= 1'b0;
    end else begin
      txd_r <= sh_r[0];
      sh_r  <= {1'b1, sh_r[9:1]};
      bit_r <= bit_r + 4'h1;
      cnt_r <= 16'(DIV - 1);
    end
  end
endmodule
`default_nettype wire

// file: remote_cal_properties.sv
// Port-level assertions for the remote calibration controller
`default_nettype none
module remote_cal_properties
  import remote_cal_pkg::*;
#(
  parameter int unsigned CAL_CYC = CAL_CYCLES
) (
  input wire logic pclk,                  // Clock
  input wire logic presetn,               // Reset, active low
  input wire logic psel,                  // APB select
  input wire logic penable,               // APB access
  input wire logic pready,                // APB ready
  input wire logic zero_req,              // Zero pin
  input wire logic span_req,              // Span pin
  input wire logic txd,                   // Serial out
  input wire logic cal_contact,           // Cal contact
  input wire logic low_range_contact,     // Range 1
  input wire logic medium_range_contact,  // Range 2
  input wire logic high_range_contact,    // Range 3
  input wire logic air_cal_range_contact, // Range 4
  input wire logic sample_valve,          // Sample valve
  input wire logic zero_valve,            // Zero valve
  input wire logic span_valve,            // Span valve
  input wire logic exhaust_valve          // Exhaust valve
);
  // ******************************
  // Closed-contact cycle count
  // ******************************
  logic [31:0] closed_r; // Cycles contact closed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      closed_r <= '0;
    else
      closed_r <= cal_contact ? closed_r + 1 : '0;
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  range_onehot_a: assert property (
    $past(presetn) |-> $onehot({low_range_contact, medium_range_contact,
      high_range_contact, air_cal_range_contact}))
    else $error("range contacts not one-hot");
  sample_open_a: assert property (
    $past(presetn) |-> sample_valve == !cal_contact)
    else $error("sample valve wrong");
  exhaust_cal_a: assert property (
    exhaust_valve == cal_contact)
    else $error("exhaust valve wrong");
  cal_valve_a: assert property (
    (zero_valve || span_valve) == cal_contact && !(zero_valve && span_valve))
    else $error("zero or span valve wrong");
  cal_length_a: assert property (
    $fell(cal_contact) |-> closed_r == CAL_CYC)
    else $error("calibration length wrong");
  held_restart_a: assert property (
    zero_req [*8] ##1 $fell(cal_contact) |=> ##[0:2] cal_contact)
    else $error("held request not restarted");
  zero_start_a: assert property (
    zero_req [*6] ##0 !cal_contact |-> ##[1:3] cal_contact && zero_valve)
    else $error("zero request not taken");
  span_start_a: assert property (
    (span_req && !zero_req) [*6] ##0 !cal_contact
      |-> ##[1:3] cal_contact && span_valve)
    else $error("span request not taken");
  apb_ready_a: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("pready timing wrong");
  start_bit_a: assert property (
    $fell(txd) |-> !txd [*8])
    else $error("start bit too short");
endmodule
`default_nettype wire

// file: host_model.sv
// Process controller and serial terminal model
`default_nettype none
module host_model #(
  parameter int DIV = 16
) (
  input  wire logic pclk,        // Clock
  input  wire logic cal_contact, // Cal contact
  input  wire logic txd,         // Analyzer serial out
  output var  logic rxd,         // Analyzer serial in
  output var  logic zero_req,    // Zero pin
  output var  logic span_req     // Span pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx_q[$]; // Bytes heard on txd
  // Idle line high, no requests
  initial begin
    rxd = 1'b1;
    zero_req = 1'b0;
    span_req = 1'b0;
  end
  // One 8N1 frame, LSB first
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge pclk);
      rxd <= f[i];
      repeat (DIV - 1) @(posedge pclk);
    end
  endtask
  // Up to three bytes, then carriage return
  task automatic send_line(input logic [23:0] s, input int n);
    for (int i = 0; i < n; i++)
      send_byte(s[23 - 8 * i -: 8]);
    send_byte(8'h0D);
  endtask
  // Request only while open, drop on closure
  task automatic remote_cal(input logic span, output logic ok);
    ok = 1'b0;
    for (int n = 0; n < 300 && cal_contact; n++) @(negedge pclk);
    @(posedge pclk);
    if (span) span_req <= 1'b1;
    else zero_req <= 1'b1;
    for (int n = 0; n < 20 && !ok; n++) begin
      @(negedge pclk);
      ok = cal_contact;
    end
    @(posedge pclk);
    zero_req <= 1'b0;
    span_req <= 1'b0;
  endtask
  // Request held regardless of contact, for refusal tests
  task automatic pulse_req(input logic span, input int cyc);
    @(posedge pclk);
    if (span) span_req <= 1'b1;
    else zero_req <= 1'b1;
    repeat (cyc) @(posedge pclk);
    zero_req <= 1'b0;
    span_req <= 1'b0;
  endtask
  // Collect report bytes, drop bad frames
  initial forever begin
    logic [7:0] b;
    @(negedge txd);
    repeat (DIV / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (DIV) @(posedge pclk);
      b[i] = txd;
    end
    repeat (DIV) @(posedge pclk);
    if (txd === 1'b1) rx_q.push_back(b);
  end
endmodule
`default_nettype wire

// file: tb_top.sv
// Testbench for the remote calibration controller
`default_nettype none
module tb_top;
  import remote_cal_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIV = 16;   // Short bit time
  localparam int RPT = 4000; // Short report period
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        zero_req, span_req, rxd, txd, cal_contact;
  logic [3:0]  rng; // Range contacts, air cal on top
  logic        samp_v, zero_v, span_v, exh_v;
  int          error_cnt, cmp_count, cyc;
  remote_cal_ctrl #(.BAUD_DIV(DIV), .REPORT_CYC(RPT), .CAL_CYC(50)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .zero_req(zero_req),
    .span_req(span_req), .rxd(rxd), .txd(txd), .cal_contact(cal_contact),
    .low_range_contact(rng[0]), .medium_range_contact(rng[1]),
    .high_range_contact(rng[2]), .air_cal_range_contact(rng[3]),
    .sample_valve(samp_v), .zero_valve(zero_v), .span_valve(span_v),
    .exhaust_valve(exh_v));
  host_model #(.DIV(DIV)) host (.pclk(pclk), .cal_contact(cal_contact),
    .txd(txd), .rxd(rxd), .zero_req(zero_req), .span_req(span_req));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // APB transfer; result is {pslverr, prdata}
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [32:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_cal(input logic lvl, input int lim);
    for (int n = 0; n < lim && cal_contact !== lvl; n++) @(negedge pclk);
  endtask
  // Wait for a gap between reports
  task automatic quiet();
    int k;
    k = 0;
    for (int i = 0; i < 20000 && k < 200; i++) begin
      @(negedge pclk);
      k = txd ? k + 1 : 0;
    end
  endtask
  task automatic wait_bytes();
    for (int i = 0; i < RPT + 4000 && host.rx_q.size() < 21; i++)
      @(negedge pclk);
  endtask
  task automatic t_reset();
    logic [32:0] r;
    check({rng, samp_v, zero_v, span_v, exh_v, cal_contact, txd}, 10'h061);
    apb(1'b0, CTRL_OFS, 32'h0, r);
    check(r, 33'h0_0000_0004);
    apb(1'b0, 8'h14, 32'h0, r);
    check(r, 33'h1_0000_0000);
  endtask
  // Pin calibrations, refused request in mid-calibration
  task automatic t_remote();
    logic ok;
    host.remote_cal(1'b0, ok);
    check(ok, 1'b1);
    check({samp_v, zero_v, span_v, exh_v}, 4'h5);
    host.pulse_req(1'b1, 10);
    wait_cal(1'b0, 300);
    repeat (30) @(negedge pclk);
    check({cal_contact, span_v, samp_v}, 3'h1);
    host.remote_cal(1'b1, ok);
    check(ok, 1'b1);
    check({samp_v, zero_v, span_v, exh_v}, 4'h3);
    wait_cal(1'b0, 300);
  endtask
  // Held request repeats, then stops once dropped
  task automatic t_held();
    fork
      host.pulse_req(1'b0, 100);
    join_none
    wait_cal(1'b1, 20);
    wait_cal(1'b0, 80);
    wait_cal(1'b1, 10);
    check(cal_contact, 1'b1);
    wait_cal(1'b0, 80);
    repeat (20) @(negedge pclk);
    check(cal_contact, 1'b0);
  endtask
  // Serial commands, bad lines and range contacts
  task automatic t_serial();
    logic [32:0] r;
    host.send_line({CH_A, CH_Z, 8'h00}, 2);
    wait_cal(1'b1, 20);
    check({cal_contact, zero_v}, 2'h3);
    wait_cal(1'b0, 80);
    host.send_line({CH_A, CH_S, 8'h00}, 2);
    wait_cal(1'b1, 20);
    check({cal_contact, span_v}, 2'h3);
    wait_cal(1'b0, 80);
    for (int d = 3; d >= 1; d--) begin
      host.send_line({CH_R, CH_M, CH_1 + 8'(d - 1)}, 3);
      repeat (10) @(negedge pclk);
      check(rng, 4'h1 << (d - 1));
    end
    host.send_line({CH_R, CH_M, CH_1 + 8'h03}, 3);
    host.send_line({CH_R, CH_M, CH_1 - 8'h01}, 3);
    host.send_line({CH_A, CH_Z, CH_Z}, 3);
    repeat (20) @(negedge pclk);
    check({cal_contact, rng}, 5'h01);
    apb(1'b1, CTRL_OFS, 32'h7, r);
    @(negedge pclk);
    check(rng, 4'h8);
    apb(1'b1, CTRL_OFS, 32'h4, r);
  endtask
  // Report content, period and on/off toggle
  task automatic t_report();
    logic [32:0] r;
    string       e;
    e = "1A2F\015\012L\015\0120000\015\012A\015\0125\015\012";
    apb(1'b1, CONC_OFS, 32'h1A2F, r);
    apb(1'b1, ALARM_OFS, 32'h5A, r);
    quiet();
    host.rx_q.delete();
    wait_bytes();
    check(host.rx_q.size(), 21);
    for (int i = 0; i < 21 && i < host.rx_q.size(); i++)
      check(host.rx_q[i], e[i]);
    host.send_line({CH_S, CH_T, 8'h00}, 2);
    quiet();
    host.rx_q.delete();
    repeat (2 * RPT) @(negedge pclk);
    check(host.rx_q.size(), 0);
    host.send_line({CH_S, CH_T, 8'h00}, 2);
    wait_bytes();
    check(host.rx_q.size() >= 21, 1'b1);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(negedge pclk);
    t_reset();
    t_remote();
    t_held();
    t_serial();
    t_report();
    tally_and_finish();
  end
endmodule
bind remote_cal_ctrl remote_cal_properties #(.CAL_CYC(CAL_CYC)) chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .zero_req(zero_req), .span_req(span_req), .txd(txd),
  .cal_contact(cal_contact), .low_range_contact(low_range_contact),
  .medium_range_contact(medium_range_contact),
  .high_range_contact(high_range_contact),
  .air_cal_range_contact(air_cal_range_contact),
  .sample_valve(sample_valve), .zero_valve(zero_valve),
  .span_valve(span_valve), .exhaust_valve(exhaust_valve));
`default_nettype wire
